// ### common/health_pkg.sv
// shared types and constants for the health word and packet output block
package health_pkg;

  // clock and processing cadence
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned CORE_RATE_HZ  = 200;
  localparam int unsigned TICK_CYCLES   = CLK_FREQ_HZ / CORE_RATE_HZ;
  localparam int unsigned INIT_TIME_S   = 60;
  localparam int unsigned INIT_TICKS    = INIT_TIME_S * CORE_RATE_HZ;

  // rate samples are signed, 0.1 deg/s per lsb
  localparam int unsigned RATE_W           = 16;
  localparam int unsigned RATE_LSB_PER_DPS = 10;
  localparam logic [15:0] TURN_THRESH_RST  = 16'(10 * RATE_LSB_PER_DPS);
  localparam logic [15:0] QUIET_THRESH     = 16'(3 * RATE_LSB_PER_DPS);
  localparam logic [15:0] OVER_RANGE_LIMIT = 16'h4e20;
  localparam int unsigned LP_SHIFT         = 3;

  // packet fifo depth
  localparam int unsigned PKT_FIFO_DEPTH = 32;

  // output rate select codes: 100, 50, 25, 20, 10, 5, 2 hz
  localparam logic [2:0] RATE_SEL_RST = 3'h0;

  // packet formats
  typedef enum logic [1:0] {
    FMT_ANGLE,
    FMT_SCALED
  } pkt_fmt_t;

  // alert category enables
  typedef struct packed {
    logic hw;
    logic sw;
    logic sensor;
    logic comm;
  } alert_en_t;

  localparam alert_en_t ALERT_EN_RST = '{hw: 1'b0, sw: 1'b1, sensor: 1'b1, comm: 1'b1};

  // configuration set loaded by the host side
  typedef struct packed {
    alert_en_t   alert_en;
    logic        turn_alert_en;
    logic        restart_switch;
    logic [15:0] turn_thresh;
    logic [2:0]  rate_sel;
    logic        stream_en;
    pkt_fmt_t    fmt;
  } cfg_t;

  localparam cfg_t CFG_RST = '{alert_en: ALERT_EN_RST, turn_alert_en: 1'b0,
                               restart_switch: 1'b0, turn_thresh: TURN_THRESH_RST,
                               rate_sel: RATE_SEL_RST, stream_en: 1'b1, fmt: FMT_ANGLE};

  // 16-bit health word, bit 15 first
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       over_range_alert;
    logic       algorithm_alert;
    logic       aiding_link_alert;
    logic       hw_alert;
    logic       any_alert_flag;
    logic [3:0] rsvd_lo;
    logic       sw_fault_flag;
    logic       link_fault_flag;
    logic       hw_fault_flag;
    logic       fatal_fault_flag;
  } health_t;

  // one measurement packet
  typedef struct packed {
    pkt_fmt_t    fmt;
    health_t     health;
    logic [15:0] field_a;
    logic [15:0] field_b;
    logic [15:0] field_c;
  } packet_t;

  // divider of the 200 hz tick for each rate select code
  function automatic logic [6:0] rate_div(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_div = 7'h02;
      3'h1:    rate_div = 7'h04;
      3'h2:    rate_div = 7'h08;
      3'h3:    rate_div = 7'h0a;
      3'h4:    rate_div = 7'h14;
      3'h5:    rate_div = 7'h28;
      default: rate_div = 7'h64;
    endcase
  endfunction : rate_div

  // magnitude of a signed rate sample
  function automatic logic [15:0] rate_abs(input logic signed [15:0] r);
    rate_abs = r[15] ? 16'(-r) : 16'(r);
  endfunction : rate_abs

endpackage : health_pkg

// ### logic/rate_lowpass.sv
// first-order low-pass of one rate axis with magnitude output
module rate_lowpass #(
  parameter int unsigned W     = 16,
  parameter int unsigned SHIFT = 3
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_ce,
  // sample in
  input  wire logic                i_tick,
  input  wire logic signed [W-1:0] i_rate,
  // filtered out
  output logic         [W-1:0]     o_abs
);
  import health_pkg::*;

  initial begin
    if (W < 2 || SHIFT < 1 || SHIFT >= W) $error("rate_lowpass: bad W or SHIFT");
  end

  logic signed [W-1:0] lp_ff;
  logic signed [W-1:0] nxt_lp;
  logic signed [W:0]   diff;
  logic signed [W:0]   sum;

  // lp += (x - lp) / 2^shift once per processing tick
  always_comb begin
    diff   = (W+1)'(i_rate) - (W+1)'(lp_ff);
    sum    = (W+1)'(lp_ff) + (diff >>> SHIFT);
    nxt_lp = i_tick ? sum[W-1:0] : lp_ff;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lp_ff <= '0;
    end else if (i_ce) begin
      lp_ff <= nxt_lp;
    end
  end

  assign o_abs = lp_ff[W-1] ? W'(-lp_ff) : W'(lp_ff);

endmodule : rate_lowpass

// ### logic/packet_fifo.sv
// synchronous valid/ready fifo for outgoing packets
module packet_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  // fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("packet_fifo: bad size");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      nxt_wr;
  logic [AW:0]      nxt_rd;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // full when pointers differ only in the wrap bit
  always_comb begin
    empty  = (wr_ff == rd_ff);
    full   = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    push   = i_ce && i_in_valid && !full;
    pop    = i_ce && i_out_ready && !empty;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage has no reset
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= i_in_data;
    end
  end

  assign o_in_ready  = i_ce && !full;
  assign o_out_valid = i_ce && !empty;
  assign o_out_data  = mem[rd_ff[AW-1:0]];

endmodule : packet_fifo

// ### logic/health_status_word_and_output.sv
// health word builder, algorithm phase tracking and packet scheduler
//
// Notes on behaviour
// - every transmitted packet carries the two-byte health word.
// - error flags sit in the low byte, enableable alerts in the high byte.
// - bit 0 is the fatal fault flag, set on a fatal error.
// - bit 1 is the hardware fault flag.
// - bit 2 is the communication fault flag.
// - bit 3 is the software fault flag.
// - bit 8 is set whenever any enabled alert is set.
// - bit 10 is set while no external aiding communication is present.
// - bit 11 is set while initializing or in high-gain state.
// - bit 12 is set while a sensor over-range exists.
// - only host-enabled alert categories feed the summary bit.
// - when enabled, the turn detect condition drives bit 11 high.
// - the turn threshold defaults to 10.0 deg/s about the vertical axis.
// - low-passed yaw rate above threshold reduces gain and flags turn.
// - inertial data and estimate update at a fixed 200 hz cadence.
// - a 60 s high-gain initialization follows start, shown in bit 11.
// - streaming runs at one of 100, 50, 25, 20, 10, 5, 2 hz.
// - a single-packet request is answered with one packet; requests that arrive while one is still pending and unpushed share it.
// - the default packet format is the angle packet.
// - with restart switch on, over-range holds fatal until rates below 3 deg/s.
module health_status_word_and_output
  import health_pkg::*;
#(
  parameter int unsigned TICK_CYC   = health_pkg::TICK_CYCLES,
  parameter int unsigned INIT_TICK  = health_pkg::INIT_TICKS,
  parameter int unsigned FIFO_DEPTH = health_pkg::PKT_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  // configuration
  input  wire health_pkg::cfg_t        i_cfg,
  input  wire logic                    i_cfg_load,
  // fault sources
  input  wire logic                    i_fatal_fault,
  input  wire logic                    i_hw_fault,
  input  wire logic                    i_link_fault,
  input  wire logic                    i_sw_fault,
  // aiding presence pin
  input  wire logic                    i_aiding_present,
  // sensor and estimate samples
  input  wire logic signed [15:0]      i_rate_x,
  input  wire logic signed [15:0]      i_rate_y,
  input  wire logic signed [15:0]      i_rate_z,
  input  wire logic        [15:0]      i_roll,
  input  wire logic        [15:0]      i_pitch,
  input  wire logic        [15:0]      i_yaw,
  // single packet request
  input  wire logic                    i_packet_req,
  // packet stream
  output logic                         o_pkt_valid,
  output health_pkg::packet_t          o_pkt_data,
  input  wire logic                    i_pkt_ready,
  // status
  output health_pkg::health_t          o_health_word,
  output logic                         o_tick,
  output logic                         o_turn_detect,
  output logic                         o_gain_reduce,
  output logic                         o_algo_restart,
  output logic                         o_req_pending
);
  import health_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYC + 1);
  localparam int unsigned IW = $clog2(INIT_TICK + 1);

  initial begin
    if (TICK_CYC < 2 || INIT_TICK < 1) $error("health block: bad timing parameters");
  end

  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_HOLD
  } algo_state_t;

  // synchroniser for the aiding pin
  logic aid_meta_ff;
  logic aid_sync_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aid_meta_ff <= 1'b0;
      aid_sync_ff <= 1'b0;
    end else if (i_ce) begin
      aid_meta_ff <= i_aiding_present;
      aid_sync_ff <= aid_meta_ff;
    end
  end

  // 200 hz processing tick
  logic [TW-1:0] tick_cnt_ff;
  logic [TW-1:0] nxt_tick_cnt;
  logic          tick;

  always_comb begin
    tick         = (tick_cnt_ff == TW'(TICK_CYC - 1));
    nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_ff <= '0;
    end else if (i_ce) begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // configuration register
  cfg_t cfg_ff;
  cfg_t nxt_cfg;

  always_comb begin
    nxt_cfg = i_cfg_load ? i_cfg : cfg_ff;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_ff <= CFG_RST;
    end else if (i_ce) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // low-passed rates, one filter per axis
  logic [15:0] lp_abs [3];
  logic signed [15:0] axis_rate [3];

  assign axis_rate[0] = i_rate_x;
  assign axis_rate[1] = i_rate_y;
  assign axis_rate[2] = i_rate_z;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_lp
      rate_lowpass #(
        .W     (RATE_W),
        .SHIFT (LP_SHIFT)
      ) u_lp (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .i_tick   (tick),
        .i_rate   (axis_rate[g]),
        .o_abs    (lp_abs[g])
      );
    end
  endgenerate

  // over-range, turn and quiet detection
  logic over_range;
  logic turn;
  logic quiet;

  always_comb begin
    over_range = (rate_abs(i_rate_x) >= OVER_RANGE_LIMIT) ||
                 (rate_abs(i_rate_y) >= OVER_RANGE_LIMIT) ||
                 (rate_abs(i_rate_z) >= OVER_RANGE_LIMIT);
    turn       = (lp_abs[2] > cfg_ff.turn_thresh);
    quiet      = (lp_abs[0] < QUIET_THRESH) && (lp_abs[1] < QUIET_THRESH) &&
                 (lp_abs[2] < QUIET_THRESH);
  end

  // algorithm phase: init countdown, run, over-range hold
  algo_state_t   state_ff;
  algo_state_t   nxt_state;
  logic [IW-1:0] init_cnt_ff;
  logic [IW-1:0] nxt_init_cnt;
  logic          restart_ff;
  logic          nxt_restart;

  always_comb begin
    nxt_state    = state_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_restart  = 1'b0;
    case (state_ff)
      ST_INIT: begin
        if (cfg_ff.restart_switch && over_range) begin
          nxt_state = ST_HOLD;
        end else if (tick) begin
          if (init_cnt_ff <= IW'(1)) begin
            nxt_state    = ST_RUN;
            nxt_init_cnt = '0;
          end else begin
            nxt_init_cnt = init_cnt_ff - 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (cfg_ff.restart_switch && over_range) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tick && quiet && !over_range) begin
          nxt_state    = ST_INIT;
          nxt_init_cnt = IW'(INIT_TICK);
          nxt_restart  = 1'b1;
        end
      end
      default: begin
        nxt_state    = ST_INIT;
        nxt_init_cnt = IW'(INIT_TICK);
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff    <= ST_INIT;
      init_cnt_ff <= IW'(INIT_TICK);
      restart_ff  <= 1'b0;
    end else if (i_ce) begin
      state_ff    <= nxt_state;
      init_cnt_ff <= nxt_init_cnt;
      restart_ff  <= nxt_restart;
    end
  end

  // health word assembly
  health_t health_ff;
  health_t nxt_health;
  logic    algo_alert;

  always_comb begin
    algo_alert = (state_ff != ST_RUN) ||
                 (cfg_ff.turn_alert_en && turn);
    nxt_health                   = '0;
    nxt_health.fatal_fault_flag  = i_fatal_fault || (state_ff == ST_HOLD);
    nxt_health.hw_fault_flag     = i_hw_fault;
    nxt_health.link_fault_flag   = i_link_fault;
    nxt_health.sw_fault_flag     = i_sw_fault;
    nxt_health.aiding_link_alert = !aid_sync_ff;
    nxt_health.algorithm_alert   = algo_alert;
    nxt_health.over_range_alert  = over_range;
    nxt_health.any_alert_flag    = (cfg_ff.alert_en.comm   && !aid_sync_ff) ||
                                   (cfg_ff.alert_en.sw     && algo_alert) ||
                                   (cfg_ff.alert_en.sensor && over_range);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      health_ff <= '0;
    end else if (i_ce) begin
      health_ff <= nxt_health;
    end
  end

  // packet scheduling: streamed rate and single requests
  logic [6:0] rate_cnt_ff;
  logic [6:0] nxt_rate_cnt;
  logic       stream_pend_ff;
  logic       nxt_stream_pend;
  logic       req_pend_ff;
  logic       nxt_req_pend;
  logic       fifo_in_ready;
  logic       push;
  logic       stream_due;
  packet_t    pkt;

  always_comb begin
    stream_due   = 1'b0;
    nxt_rate_cnt = rate_cnt_ff;
    if (!cfg_ff.stream_en) begin
      nxt_rate_cnt = '0;
    end else if (tick) begin
      if (rate_cnt_ff >= rate_div(cfg_ff.rate_sel) - 7'h01) begin
        nxt_rate_cnt = '0;
        stream_due   = 1'b1;
      end else begin
        nxt_rate_cnt = rate_cnt_ff + 7'h01;
      end
    end
    push = (stream_pend_ff || req_pend_ff) && fifo_in_ready;
    // a new request or due slot wins over the clear of its flag
    nxt_stream_pend = stream_due || (stream_pend_ff && !push);
    nxt_req_pend    = i_packet_req ||
                      (req_pend_ff && !(push && !stream_pend_ff));
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_cnt_ff    <= '0;
      stream_pend_ff <= 1'b0;
      req_pend_ff    <= 1'b0;
    end else if (i_ce) begin
      rate_cnt_ff    <= nxt_rate_cnt;
      stream_pend_ff <= nxt_stream_pend;
      req_pend_ff    <= nxt_req_pend;
    end
  end

  // packet contents: angles or scaled rates, always with the health word
  always_comb begin
    pkt.fmt    = cfg_ff.fmt;
    pkt.health = health_ff;
    if (cfg_ff.fmt == FMT_ANGLE) begin
      pkt.field_a = i_roll;
      pkt.field_b = i_pitch;
      pkt.field_c = i_yaw;
    end else begin
      pkt.field_a = i_rate_x;
      pkt.field_b = i_rate_y;
      pkt.field_c = i_rate_z;
    end
  end

  packet_fifo #(
    .WIDTH ($bits(packet_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_in_valid  (stream_pend_ff || req_pend_ff),
    .i_in_data   (pkt),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_pkt_valid),
    .o_out_data  (o_pkt_data),
    .i_out_ready (i_pkt_ready)
  );

  // status outputs
  assign o_health_word  = health_ff;
  assign o_tick         = tick && i_ce;
  assign o_turn_detect  = turn;
  assign o_gain_reduce  = turn || (state_ff != ST_RUN);
  assign o_algo_restart = restart_ff;
  assign o_req_pending  = req_pend_ff;

endmodule : health_status_word_and_output

// ### testbench/health_status_word_and_output_properties.sv
// concurrent checks on the health word and packet output ports
module health_status_word_and_output_checker
  import health_pkg::*;
#(
  parameter int unsigned TICK_CYC = health_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_ce,
  // watched inputs
  input  wire health_pkg::cfg_t    i_cfg,
  input  wire logic                i_cfg_load,
  input  wire logic                i_fatal_fault,
  input  wire logic                i_hw_fault,
  input  wire logic                i_link_fault,
  input  wire logic                i_sw_fault,
  input  wire logic                i_aiding_present,
  input  wire logic signed [15:0]  i_rate_z,
  input  wire logic                i_packet_req,
  input  wire logic                i_pkt_ready,
  // watched outputs
  input  wire logic                o_pkt_valid,
  input  wire health_pkg::packet_t o_pkt_data,
  input  wire health_pkg::health_t o_health_word,
  input  wire logic                o_tick,
  input  wire logic                o_turn_detect,
  input  wire logic                o_gain_reduce,
  input  wire logic                o_req_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_ff, nxt_gap;
  logic        seen_ff, nxt_seen;
  alert_en_t   en_ff, nxt_en;

  // cycles since the last tick and a shadow of the alert enables
  always_comb begin
    nxt_gap  = o_tick ? 32'h0 : gap_ff + 32'(i_ce);
    nxt_seen = seen_ff | o_tick;
    nxt_en   = i_cfg_load ? i_cfg.alert_en : en_ff;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_ff  <= 32'h0;
      seen_ff <= 1'b0;
      en_ff   <= ALERT_EN_RST;
    end else begin
      gap_ff  <= nxt_gap;
      seen_ff <= nxt_seen;
      en_ff   <= nxt_en;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // a fresh request is pending one edge later and offered the edge after
  sequence s_req_new;
    i_ce && i_packet_req && !o_req_pending && !o_pkt_valid;
  endsequence
  sequence s_req_served;
    o_req_pending ##1 o_pkt_valid;
  endsequence

  AST_RSVD_ZERO: assert property (
    {o_health_word.rsvd_hi, o_health_word.hw_alert, o_health_word.rsvd_lo} == 8'h00)
    else $error("reserved health bits set");
  AST_FATAL_BIT: assert property (i_ce && i_fatal_fault |=> o_health_word.fatal_fault_flag)
    else $error("fatal flag missing");
  AST_FAULT_BITS: assert property (i_ce |=>
    o_health_word[3:1] == $past({i_sw_fault, i_link_fault, i_hw_fault}))
    else $error("fault bits wrong");
  AST_AIDING_LOST: assert property (
    (i_ce && !i_aiding_present) [*3] |=> o_health_word.aiding_link_alert)
    else $error("aiding alert missing");
  AST_OVER_RANGE: assert property (
    i_ce && (i_rate_z >= 16'sh4e20 || i_rate_z <= -16'sh4e20) |=> o_health_word.over_range_alert)
    else $error("over range alert missing");
  AST_ANY_ALERT: assert property (!$past(i_cfg_load) |->
    o_health_word.any_alert_flag == ((en_ff.comm & o_health_word.aiding_link_alert) |
    (en_ff.sw & o_health_word.algorithm_alert) | (en_ff.sensor & o_health_word.over_range_alert)))
    else $error("summary alert wrong");
  AST_REQ_SERVED: assert property (s_req_new |=> s_req_served)
    else $error("request not served");
  AST_VALID_HOLD: assert property (
    i_ce && o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_data))
    else $error("packet dropped while stalled");
  AST_TURN_GAIN: assert property (o_turn_detect |-> o_gain_reduce)
    else $error("turn without gain cut");
  AST_TICK_GAP: assert property ((gap_ff < TICK_CYC) &&
    (o_tick && seen_ff -> gap_ff == TICK_CYC - 1))
    else $error("tick spacing wrong");
endmodule : health_status_word_and_output_checker

bind health_status_word_and_output health_status_word_and_output_checker #(
  .TICK_CYC(TICK_CYC)
) u_checker (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_cfg(i_cfg), .i_cfg_load(i_cfg_load),
  .i_fatal_fault(i_fatal_fault), .i_hw_fault(i_hw_fault), .i_link_fault(i_link_fault),
  .i_sw_fault(i_sw_fault), .i_aiding_present(i_aiding_present), .i_rate_z(i_rate_z),
  .i_packet_req(i_packet_req), .i_pkt_ready(i_pkt_ready), .o_pkt_valid(o_pkt_valid),
  .o_pkt_data(o_pkt_data), .o_health_word(o_health_word), .o_tick(o_tick),
  .o_turn_detect(o_turn_detect), .o_gain_reduce(o_gain_reduce), .o_req_pending(o_req_pending));

// ### testbench/host_reader.sv
// host model draining the packet stream, able to stall
module host_reader (
  // clock and stall control
  input  wire logic                i_clk,
  input  wire logic                i_stall,
  // packet stream from the device
  input  wire logic                i_valid,
  input  wire health_pkg::packet_t i_data,
  output logic                     o_ready,
  // received packets
  output int                       o_count,
  output health_pkg::packet_t      o_last
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_ready = 1'b0;
    o_count = 0;
    o_last  = '0;
  end

  // take a packet where valid and ready meet, move ready just after the edge
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      o_count <= o_count + 1;
      o_last  <= i_data;
    end
    o_ready <= #1 !i_stall;
  end
endmodule : host_reader

// ### testbench/health_status_word_and_output_tb.sv
// self-checking bench for the health word and packet output block
module health_status_word_and_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import health_pkg::*;
  localparam int TCYC = 20;
  localparam int ITCK = 5;
  logic i_clk = 1'b0;
  logic i_resetn, i_ce, i_cfg_load, i_packet_req, i_pkt_ready, stall;
  logic i_fatal_fault, i_hw_fault, i_link_fault, i_sw_fault, i_aiding_present;
  logic signed [15:0] i_rate_x, i_rate_y, i_rate_z;
  logic [15:0] i_roll, i_pitch, i_yaw;
  cfg_t    i_cfg, c;
  packet_t o_pkt_data, hlast;
  health_t o_health_word;
  logic o_pkt_valid, o_tick, o_turn_detect, o_gain_reduce, o_algo_restart, o_req_pending;
  int failures = 0, check_count = 0, ticks = 0, hcount, n, n0, k;
  int divs[7] = '{2, 4, 8, 10, 20, 40, 100};

  // 25 mhz clock and a tick tally
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_tick) ticks <= ticks + 1;

  health_status_word_and_output #(.TICK_CYC(TCYC), .INIT_TICK(ITCK), .FIFO_DEPTH(32)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_cfg(i_cfg), .i_cfg_load(i_cfg_load),
    .i_fatal_fault(i_fatal_fault), .i_hw_fault(i_hw_fault), .i_link_fault(i_link_fault),
    .i_sw_fault(i_sw_fault), .i_aiding_present(i_aiding_present), .i_rate_x(i_rate_x),
    .i_rate_y(i_rate_y), .i_rate_z(i_rate_z), .i_roll(i_roll), .i_pitch(i_pitch),
    .i_yaw(i_yaw), .i_packet_req(i_packet_req), .o_pkt_valid(o_pkt_valid),
    .o_pkt_data(o_pkt_data), .i_pkt_ready(i_pkt_ready), .o_health_word(o_health_word),
    .o_tick(o_tick), .o_turn_detect(o_turn_detect), .o_gain_reduce(o_gain_reduce),
    .o_algo_restart(o_algo_restart), .o_req_pending(o_req_pending));

  host_reader host (.i_clk(i_clk), .i_stall(stall), .i_valid(o_pkt_valid),
    .i_data(o_pkt_data), .o_ready(i_pkt_ready), .o_count(hcount), .o_last(hlast));

  // advance n edges and settle just after the last one
  task automatic step(input int num);
    repeat (num) @(posedge i_clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic expire(input string what);
    failures++;
    $display("mismatch %s expected event seen timeout", what);
    give_verdict();
  endtask : expire

  // one-cycle configuration load pulse
  task automatic load(input cfg_t cv);
    i_cfg = cv;
    i_cfg_load = 1'b1;
    step(1);
    i_cfg_load = 1'b0;
  endtask : load

  // wait for the host to hold a packet count, returning the cycles taken
  task automatic wait_cnt(input int target, output int cyc);
    cyc = 0;
    while (hcount < target && cyc < 5000) begin
      step(1);
      cyc++;
    end
    if (hcount < target) expire("packet count");
  endtask : wait_cnt

  initial begin
    {i_resetn, i_cfg_load, i_packet_req, stall, i_aiding_present} = '0;
    {i_fatal_fault, i_hw_fault, i_link_fault, i_sw_fault} = '0;
    {i_rate_x, i_rate_y, i_rate_z} = '0;
    i_ce = 1'b1;
    {i_roll, i_pitch, i_yaw} = {16'h1234, 16'h5678, 16'h9abc};
    i_cfg = CFG_RST;
    step(4);
    i_resetn = 1'b1;
    step(1);
    check("reset word", 16'h0d00, o_health_word);
    // walk each error bit with aiding present, still initializing
    i_aiding_present = 1'b1;
    step(4);
    for (int b = 0; b < 5; b++) begin
      {i_sw_fault, i_link_fault, i_hw_fault, i_fatal_fault} = 4'(1 << b);
      step(2);
      check("fault word", 16'h0900 | ((16'h1 << b) & 16'h000f), o_health_word);
    end
    // over range both signs
    i_rate_z = 16'sh4e20;
    step(2);
    check("over word", 16'h1900, o_health_word);
    i_rate_z = -16'sh4e20;
    step(2);
    check("over word", 16'h1900, o_health_word);
    i_rate_z = '0;
    // initialization length in ticks
    for (k = 0; o_health_word.algorithm_alert !== 1'b0 && k < 1000; k++) step(1);
    if (k == 1000) expire("init end");
    check("init ticks", ITCK, ticks);
    check("run word", 16'h0000, o_health_word);
    // every stream rate, packet spacing in cycles
    for (int s = 0; s < 7; s++) begin
      c = CFG_RST;
      c.rate_sel = 3'(s);
      load(c);
      wait_cnt(hcount + 1, n);
      wait_cnt(hcount + 1, n);
      wait_cnt(hcount + 1, n);
      check("period", divs[s] * TCYC, n);
    end
    check("fmt", FMT_ANGLE, hlast.fmt);
    check("fields", {i_roll, i_pitch, i_yaw}, {hlast.field_a, hlast.field_b, hlast.field_c});
    check("pkt health", 16'h0000, hlast.health);
    // requests only: fill the buffer while the host stalls, then drain
    c = CFG_RST;
    c.stream_en = 1'b0;
    c.fmt = FMT_SCALED;
    load(c);
    step(40);
    stall = 1'b1;
    step(2);
    n0 = hcount;
    i_packet_req = 1'b1;
    step(40);
    i_packet_req = 1'b0;
    step(4);
    check("held valid", 1'b1, o_pkt_valid);
    stall = 1'b0;
    wait_cnt(n0 + 33, n);
    step(20);
    check("req pkts", 33, hcount - n0);
    check("scaled", {FMT_SCALED, 48'h0}, {hlast.fmt, hlast.field_a, hlast.field_b, hlast.field_c});
    // turn detect at and above the default threshold
    c.turn_alert_en = 1'b1;
    load(c);
    i_rate_z = 16'sd100;
    step(800);
    check("turn at limit", 1'b0, o_turn_detect);
    i_rate_z = 16'sd120;
    for (k = 0; o_turn_detect !== 1'b1 && k < 2000; k++) step(1);
    if (k == 2000) expire("turn");
    step(2);
    check("turn word", 16'h0900, o_health_word);
    check("gain cut", 1'b1, o_gain_reduce);
    c.alert_en.sw = 1'b0;
    load(c);
    step(2);
    check("masked word", 16'h0800, o_health_word);
    i_rate_z = '0;
    // over range with restart switch holds fatal until quiet
    c = CFG_RST;
    c.stream_en = 1'b0;
    c.restart_switch = 1'b1;
    load(c);
    i_rate_x = 16'sh4e20;
    step(2);
    check("fatal", 1'b1, o_health_word.fatal_fault_flag);
    step(2 * TCYC);
    check("fatal held", 1'b1, o_health_word.fatal_fault_flag);
    i_rate_x = '0;
    for (k = 0; o_algo_restart !== 1'b1 && k < 3000; k++) step(1);
    if (k == 3000) expire("restart");
    step(2);
    check("restart word", 16'h0900, o_health_word);
    give_verdict();
  end
endmodule : health_status_word_and_output_tb
